// file: verilog/sic_pkg.sv
// Constants shared by the status indicator control block.
package sic_pkg;
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned RED_TEST_MS    = 1000;
  localparam int unsigned LAMP_TEST_MS   = 2000;
  localparam int unsigned FLASH_HALF_MS  = 250;
  localparam int unsigned MS_CYCLES      = CLK_HZ / 1000;
  localparam int unsigned RED_TEST_CYC   = RED_TEST_MS * MS_CYCLES;
  localparam int unsigned LAMP_TEST_CYC  = LAMP_TEST_MS * MS_CYCLES;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * MS_CYCLES;
  localparam int unsigned NUM_INPUTS     = 16;
  localparam logic [1:0]  LED_OFF        = 2'h0;
  localparam logic [1:0]  LED_GREEN      = 2'h1;
  localparam logic [1:0]  LED_RED        = 2'h2;
  typedef enum logic [2:0] {
    SIC_ST_POWER_TEST,
    SIC_ST_WAIT_SELFTEST,
    SIC_ST_RUN,
    SIC_ST_FAULT
  } sic_state_e;
endpackage

// file: verilog/sic_divider.sv
// One-cycle enable pulse every period cycles.
`timescale 1ns/10ps
`default_nettype none
module sic_divider #(
  parameter int unsigned PERIOD = 4
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  output logic      tick_out
);
  localparam int unsigned CW = $clog2(PERIOD + 1);
  logic [CW-1:0] cnt_ff;
  wire           at_end = (cnt_ff == CW'(PERIOD - 1));

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || at_end) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= at_end;
    end
  end
endmodule
`default_nettype wire

// file: verilog/sic_status_indicator.sv
// Front-panel health and per-input indicator driver.
`timescale 1ns/10ps
`default_nettype none
module sic_status_indicator
  import sic_pkg::*;
#(
  parameter int unsigned N_IN       = sic_pkg::NUM_INPUTS,
  parameter int unsigned RED_CYC    = sic_pkg::RED_TEST_CYC,
  parameter int unsigned LAMP_CYC   = sic_pkg::LAMP_TEST_CYC,
  parameter int unsigned FLASH_CYC  = sic_pkg::FLASH_HALF_CYC
) (
  input  wire logic            clk_sys_in,
  input  wire logic            rst_in,
  input  wire logic            selftest_done_in,
  input  wire logic            selftest_pass_in,
  input  wire logic            multicasting_in,
  input  wire logic            conn_timeout_in,
  input  wire logic            fw_update_in,
  input  wire logic            fatal_error_in,
  input  wire logic [N_IN-1:0] input_active_in,
  output logic                 health_red_out,
  output logic                 health_green_out,
  output logic [N_IN-1:0]      input_led_out
);
  import sic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned TW = $clog2(LAMP_CYC + 1);

  sic_state_e     state_ff;
  sic_state_e     nxt_state;
  logic [TW-1:0]  timer_ff;
  logic           flash_ff;
  logic           flash_tick;
  logic [1:0]     nxt_colour;
  logic           nxt_lamp_on;

  wire red_done  = (timer_ff >= TW'(RED_CYC - 1));
  wire lamp_done = (timer_ff >= TW'(LAMP_CYC - 1));
  wire selftest_ok  = selftest_done_in && selftest_pass_in;
  wire selftest_bad = selftest_done_in && !selftest_pass_in;
  wire flash_red_req = conn_timeout_in || fw_update_in;

  ////////////////////////////////////////////////////////////////////////////
  // fixed flash rate
  sic_divider #(
    .PERIOD (FLASH_CYC)
  ) u_flash_div (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .tick_out   (flash_tick)
  );

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      flash_ff <= 1'b0;
    end else if (flash_tick) begin
      flash_ff <= ~flash_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The timer runs from reset and saturates once the lamp test has ended.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      timer_ff <= '0;
    end else if (!lamp_done) begin
      timer_ff <= timer_ff + 1'b1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SIC_ST_POWER_TEST: begin
        if (red_done) begin
          nxt_state = SIC_ST_WAIT_SELFTEST;
        end
      end
      // A failed self-test counts as an unrecoverable error.
      SIC_ST_WAIT_SELFTEST: begin
        if (selftest_ok) begin
          nxt_state = SIC_ST_RUN;
        end else if (selftest_bad) begin
          nxt_state = SIC_ST_FAULT;
        end
      end
      SIC_ST_RUN: begin
        nxt_state = SIC_ST_RUN;
      end
      SIC_ST_FAULT: begin
        nxt_state = SIC_ST_FAULT;
      end
      default: begin
        nxt_state = SIC_ST_FAULT;
      end
    endcase
    if (fatal_error_in) begin
      nxt_state = SIC_ST_FAULT;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_ff <= SIC_ST_POWER_TEST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_colour = LED_OFF;
    unique case (nxt_state)
      SIC_ST_POWER_TEST: begin
        nxt_colour = LED_RED;
      end
      // Self-test still pending: hold red until it reports.
      SIC_ST_WAIT_SELFTEST: begin
        nxt_colour = LED_RED;
      end
      SIC_ST_RUN: begin
        if (flash_red_req) begin
          nxt_colour = flash_ff ? LED_RED : LED_OFF;
        end else if (multicasting_in) begin
          nxt_colour = LED_GREEN;
        end else begin
          nxt_colour = flash_ff ? LED_GREEN : LED_OFF;
        end
      end
      SIC_ST_FAULT: begin
        nxt_colour = LED_RED;
      end
      default: begin
        nxt_colour = LED_RED;
      end
    endcase
  end

  assign nxt_lamp_on = !lamp_done;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      health_red_out   <= 1'b0;
      health_green_out <= 1'b0;
    end else begin
      health_red_out   <= nxt_colour[1];
      health_green_out <= nxt_colour[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input indicators follow inputs once the lamp test has ended; all lit before that
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      input_led_out <= '0;
    end else if (nxt_lamp_on) begin
      input_led_out <= '1;
    end else begin
      input_led_out <= input_active_in;
    end
  end
endmodule
`default_nettype wire

// file: test/sic_ctrl_model.sv
// Behavioural model of the owning controller.
`timescale 1ns/10ps
`default_nettype none
module sic_ctrl_model (
  input  wire logic   clk_sys_in,
  input  wire logic   rst_in,
  input  wire logic   link_up_in,
  output logic        timeout_out,
  output logic [15:0] fault_word_out
);
  logic seen_ff;
  always_ff @(posedge clk_sys_in) begin
    seen_ff <= !rst_in && (seen_ff || link_up_in);
    timeout_out <= !rst_in && seen_ff && !link_up_in;
  end
  assign fault_word_out = timeout_out ? 16'hffff : 16'h0000;
endmodule
`default_nettype wire

// file: test/sic_assertions.sv
// Concurrent checks on the indicator ports.
`timescale 1ns/10ps
`default_nettype none
module sic_assertions #(parameter int unsigned N_IN = 16, RED_CYC = 20, LAMP_CYC = 40, FLASH_CYC = 4) (
  input wire logic            clk_sys_in,
  input wire logic            rst_in,
  input wire logic            selftest_done_in,
  input wire logic            selftest_pass_in,
  input wire logic            multicasting_in,
  input wire logic            conn_timeout_in,
  input wire logic            fw_update_in,
  input wire logic            fatal_error_in,
  input wire logic [N_IN-1:0] input_active_in,
  input wire logic            health_red_out,
  input wire logic            health_green_out,
  input wire logic [N_IN-1:0] input_led_out
);
  logic [6:0] cnt_ff;
  logic       fat_ff;
  wire ok = cnt_ff == 7'h7f && !fat_ff && selftest_done_in && selftest_pass_in;
  wire fr = ok && (conn_timeout_in || fw_update_in);
  wire fg = ok && !conn_timeout_in && !fw_update_in && !multicasting_in;
  wire sg = ok && !conn_timeout_in && !fw_update_in && multicasting_in;
  always_ff @(posedge clk_sys_in) begin
    cnt_ff <= rst_in ? 7'h00 : cnt_ff + {6'h00, cnt_ff != 7'h7f};
    fat_ff <= !rst_in && (fat_ff || fatal_error_in);
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  AST_ONE_COLOUR: assert property (!(health_red_out && health_green_out)) else $error("both lit");
  AST_POWER_RED: assert property (cnt_ff inside {[2:RED_CYC-3]} |-> health_red_out && !health_green_out)
    else $error("power red");
  AST_LAMP: assert property (cnt_ff inside {[2:LAMP_CYC-3]} |-> &input_led_out) else $error("lamp");
  AST_LED: assert property (cnt_ff > LAMP_CYC + 1 |-> input_led_out == $past(input_active_in)) else $error("led");
  AST_STEADY: assert property (sg[*3] |-> health_green_out && !health_red_out) else $error("steady");
  AST_FLASH_G: assert property (fg[*6] |-> !health_red_out && health_green_out != $past(health_green_out, FLASH_CYC))
    else $error("flash green");
  AST_FLASH_R: assert property (fr[*6] |-> !health_green_out && health_red_out != $past(health_red_out, FLASH_CYC))
    else $error("flash red");
  AST_FATAL: assert property (fat_ff |=> health_red_out && !health_green_out) else $error("fatal");
endmodule
bind sic_status_indicator sic_assertions #(.N_IN(N_IN), .RED_CYC(RED_CYC), .LAMP_CYC(LAMP_CYC), .FLASH_CYC(FLASH_CYC))
  sic_assertions_i (.*);
`default_nettype wire

// file: test/sic_status_indicator_test.sv
// Testbench for the status indicator block.
`timescale 1ns/10ps
`default_nettype none
`define CK(a,b) begin compares++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module sic_status_indicator_test;
  logic        clk_sys_in = 0, rst_in = 1, done = 1, pass = 1, mc = 0, fw = 0, fat = 0, link = 0, to, red, grn;
  logic [15:0] act = 16'ha5c3, led, fault;
  int          fails = 0, compares = 0, cyc = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  sic_ctrl_model sic_ctrl_model_i (.clk_sys_in, .rst_in, .link_up_in(link), .timeout_out(to), .fault_word_out(fault));
  sic_status_indicator #(.RED_CYC(20), .LAMP_CYC(40), .FLASH_CYC(4)) sic_status_indicator_i (.clk_sys_in, .rst_in,
    .selftest_done_in(done), .selftest_pass_in(pass), .multicasting_in(mc), .conn_timeout_in(to), .fw_update_in(fw),
    .fatal_error_in(fat), .input_active_in(act), .health_red_out(red), .health_green_out(grn), .input_led_out(led));
  task automatic wt(int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic flashes(logic r, int exp);
    logic p;
    int   n;
    n = 0;
    p = r ? red : grn;
    repeat (16) begin
      wt(1);
      if ((r ? red : grn) !== p) n++;
      p = r ? red : grn;
      `CK(r ? grn : red, 1'b0)
    end
    `CK(n, exp)
  endtask
  // A mid-run reset with a failing self-test must end in steady red.
  task automatic selftest_fail;
    rst_in = 1;
    pass = 0;
    wt(3);
    rst_in = 0;
    wt(1);
    `CK({red, grn, led}, 18'h2ffff)
    wt(60);
    `CK({red, grn, led}, {2'b10, act})
  endtask
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    wt(3);
    rst_in = 0;
    wt(10);
    `CK({red, grn, led}, 18'h2ffff)
    wt(120);
    `CK({red, led}, {1'b0, act})
    flashes(0, 4);
    mc = 1;
    wt(3);
    flashes(0, 0);
    `CK(grn, 1'b1)
    link = 1;
    wt(3);
    link = 0;
    wt(4);
    flashes(1, 4);
    `CK(fault, 16'hffff)
    link = 1;
    fw = 1;
    wt(4);
    flashes(1, 4);
    fw = 0;
    fat = 1;
    wt(1);
    fat = 0;
    wt(3);
    flashes(1, 0);
    `CK(red, 1'b1)
    selftest_fail();
    test_done;
  end
endmodule
`default_nettype wire
